// ===== rtl/spcmd_map.vh
`ifndef SPCMD_MAP_VH
`define SPCMD_MAP_VH

// Command codes
`define SPCMD_OP_W          4
`define SPCMD_OP_NOP        4'h0
`define SPCMD_OP_OUT_WR     4'h1
`define SPCMD_OP_OUT_RD     4'h2
`define SPCMD_OP_IN_RD      4'h3
`define SPCMD_OP_PRN_STOP   4'h4
`define SPCMD_OP_PRN_START  4'h5
`define SPCMD_OP_TEMP_EN    4'h6
`define SPCMD_OP_COUNT_EN   4'h7
`define SPCMD_OP_TAG_EN     4'h8
`define SPCMD_OP_CLOCK_EN   4'h9

// Answer status codes
`define SPCMD_ST_OK         2'h0
`define SPCMD_ST_BUSY       2'h1
`define SPCMD_ST_CAL        2'h2
`define SPCMD_ST_BADCMD     2'h3

// Widths and reset values
`define SPCMD_OUT_W         3
`define SPCMD_IN_W          4
`define SPCMD_OUT_RST       3'h0
`define SPCMD_FLAG_RST      1'b0

// Print flag file: index of each enable flag
`define SPCMD_FLAG_N        4
`define SPCMD_FLAG_AW       2
`define SPCMD_FLAG_TEMP     2'h0
`define SPCMD_FLAG_COUNT    2'h1
`define SPCMD_FLAG_TAG      2'h2
`define SPCMD_FLAG_CLOCK    2'h3

`endif

// ===== rtl/spcmd_flag_mem.v
`include "spcmd_map.vh"
`default_nettype none

// ****************************************
// Print enable flag store
// ****************************************
module spcmd_flag_mem
(
    input  wire                       ref_clk,
    input  wire                       rst_n,
    input  wire                       wr_en,
    input  wire [`SPCMD_FLAG_AW-1:0]  wr_addr,
    input  wire                       wr_data,
    input  wire [`SPCMD_FLAG_AW-1:0]  rd_addr,
    output reg                        rd_data_r,
    output wire [`SPCMD_FLAG_N-1:0]   flags
);

    reg [`SPCMD_FLAG_N-1:0] mem_r;

    genvar g;
    generate
        for (g = 0; g < `SPCMD_FLAG_N; g = g + 1)
        begin : g_flag
            always @(posedge ref_clk)
            begin
                if (!rst_n)
                    mem_r[g] <= `SPCMD_FLAG_RST;
                else if (wr_en && wr_addr == g)
                    mem_r[g] <= wr_data;
            end
        end
    endgenerate

    // Read data registered; a same-cycle write shows the new value
    always @(posedge ref_clk)
    begin
        if (!rst_n)
            rd_data_r <= 1'b0;
        else if (wr_en && wr_addr == rd_addr)
            rd_data_r <= wr_data;
        else
            rd_data_r <= mem_r[rd_addr];
    end

    assign flags = mem_r;

endmodule

`default_nettype wire

// ===== rtl/spcmd_top.v
`include "spcmd_map.vh"
`default_nettype none

module spcmd_top
(
    input  wire                      ref_clk,
    input  wire                      rst_n,
    input  wire                      cmd_valid,
    input  wire [`SPCMD_OP_W-1:0]    cmd_op,
    input  wire                      cmd_query,
    input  wire [`SPCMD_OUT_W-1:0]   cmd_value,
    input  wire                      meas_running,
    input  wire                      cal_mode,
    input  wire                      temp_comp_on,
    input  wire [`SPCMD_IN_W-1:0]    spare_in,
    output reg                       rsp_valid_r,
    output reg  [1:0]                rsp_status_r,
    output reg  [`SPCMD_IN_W-1:0]    rsp_data_r,
    output reg  [`SPCMD_OUT_W-1:0]   spare_out_r,
    output reg                       printer_on_r,
    output reg                       prt_temp_r,
    output reg                       prt_count_r,
    output reg                       prt_tag_r,
    output reg                       prt_clock_r
);

    // ****************************************
    // Command classification
    // ****************************************
    function is_item;
        input [`SPCMD_OP_W-1:0] op;
        begin
            is_item = (op == `SPCMD_OP_TEMP_EN) ||
                      (op == `SPCMD_OP_COUNT_EN) ||
                      (op == `SPCMD_OP_TAG_EN) ||
                      (op == `SPCMD_OP_CLOCK_EN);
        end
    endfunction

    function [`SPCMD_FLAG_AW-1:0] item_idx;
        input [`SPCMD_OP_W-1:0] op;
        begin
            case (op)
                `SPCMD_OP_TEMP_EN:  item_idx = `SPCMD_FLAG_TEMP;
                `SPCMD_OP_COUNT_EN: item_idx = `SPCMD_FLAG_COUNT;
                `SPCMD_OP_TAG_EN:   item_idx = `SPCMD_FLAG_TAG;
                default:            item_idx = `SPCMD_FLAG_CLOCK;
            endcase
        end
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Spare inputs are pins: two stages before anything reads them
    reg [`SPCMD_IN_W-1:0] in_s1_r;
    reg [`SPCMD_IN_W-1:0] in_s2_r;

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            in_s1_r <= {`SPCMD_IN_W{1'b0}};
            in_s2_r <= {`SPCMD_IN_W{1'b0}};
        end
        else
        begin
            in_s1_r <= spare_in;
            in_s2_r <= in_s1_r;
        end
    end

    // ****************************************
    // Decode and admission
    // ****************************************
    wire gen_cmd = (cmd_op == `SPCMD_OP_OUT_WR) ||
                   (cmd_op == `SPCMD_OP_OUT_RD) ||
                   (cmd_op == `SPCMD_OP_IN_RD) || is_item(cmd_op);
    wire prn_cmd = (cmd_op == `SPCMD_OP_PRN_STOP) ||
                   (cmd_op == `SPCMD_OP_PRN_START);
    wire known   = gen_cmd || prn_cmd;

    // Calibration reported ahead of busy when both hold
    reg [1:0] status_nxt;
    always @*
    begin
        if (!known)
            status_nxt = `SPCMD_ST_BADCMD;
        else if (cal_mode)
            status_nxt = `SPCMD_ST_CAL;
        else if (gen_cmd && meas_running)
            status_nxt = `SPCMD_ST_BUSY;
        else
            status_nxt = `SPCMD_ST_OK;
    end

    wire accept = cmd_valid && (status_nxt == `SPCMD_ST_OK);
    wire do_set = accept && !cmd_query;

    // ****************************************
    // Print enable flags
    // ****************************************
    wire                      flag_rd;
    wire [`SPCMD_FLAG_N-1:0]  flags;
    wire                      flag_wr = do_set && is_item(cmd_op);

    // Any nonzero parameter counts as ON
    spcmd_flag_mem u_flags
    (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .wr_en     (flag_wr),
        .wr_addr   (item_idx(cmd_op)),
        .wr_data   (|cmd_value),
        .rd_addr   (item_idx(cmd_op)),
        .rd_data_r (flag_rd),
        .flags     (flags)
    );

    // ****************************************
    // Latches and printer state
    // ****************************************
    reg                    pend_r;
    reg [`SPCMD_OP_W-1:0]  pend_op_r;
    reg [1:0]              pend_st_r;

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            spare_out_r  <= `SPCMD_OUT_RST;
            printer_on_r <= 1'b0;
        end
        else if (do_set)
        begin
            case (cmd_op)
                `SPCMD_OP_OUT_WR:    spare_out_r  <= cmd_value;
                `SPCMD_OP_PRN_STOP:  printer_on_r <= 1'b0;
                `SPCMD_OP_PRN_START: printer_on_r <= 1'b1;
                default:             printer_on_r <= printer_on_r;
            endcase
        end
    end

    // Flag outputs follow the store one cycle late
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            prt_temp_r  <= 1'b0;
            prt_count_r <= 1'b0;
            prt_tag_r   <= 1'b0;
            prt_clock_r <= 1'b0;
        end
        else
        begin
            // Temperature only printed with compensation active
            prt_temp_r  <= flags[`SPCMD_FLAG_TEMP] & temp_comp_on;
            prt_count_r <= flags[`SPCMD_FLAG_COUNT];
            prt_tag_r   <= flags[`SPCMD_FLAG_TAG];
            prt_clock_r <= flags[`SPCMD_FLAG_CLOCK];
        end
    end

    // ****************************************
    // Answer path
    // ****************************************
    // Stage one: note the command; the flag store read lands meanwhile
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pend_r    <= 1'b0;
            pend_op_r <= `SPCMD_OP_NOP;
            pend_st_r <= `SPCMD_ST_OK;
        end
        else
        begin
            pend_r    <= cmd_valid;
            pend_op_r <= cmd_op;
            pend_st_r <= status_nxt;
        end
    end

    reg [`SPCMD_IN_W-1:0] data_nxt;
    always @*
    begin
        data_nxt = {`SPCMD_IN_W{1'b0}};
        if (pend_st_r == `SPCMD_ST_OK)
        begin
            case (pend_op_r)
                `SPCMD_OP_OUT_WR,
                `SPCMD_OP_OUT_RD:
                    data_nxt = {1'b0, spare_out_r};
                `SPCMD_OP_IN_RD:
                    data_nxt = in_s2_r;
                `SPCMD_OP_PRN_STOP,
                `SPCMD_OP_PRN_START:
                    data_nxt = {3'h0, printer_on_r};
                `SPCMD_OP_TEMP_EN,
                `SPCMD_OP_COUNT_EN,
                `SPCMD_OP_TAG_EN,
                `SPCMD_OP_CLOCK_EN:
                    data_nxt = {3'h0, flag_rd};
                default:
                    data_nxt = {`SPCMD_IN_W{1'b0}};
            endcase
        end
    end

    // Every command is answered, refusals with a status code
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rsp_valid_r  <= 1'b0;
            rsp_status_r <= `SPCMD_ST_OK;
            rsp_data_r   <= {`SPCMD_IN_W{1'b0}};
        end
        else
        begin
            rsp_valid_r  <= pend_r;
            rsp_status_r <= pend_st_r;
            rsp_data_r   <= data_nxt;
        end
    end

endmodule

`default_nettype wire

// ===== dv/spcmd_host.sv
`default_nettype none
// ****************
// Remote host model
// ****************
module spcmd_host
(
    input  wire logic       ref_clk,
    output var  logic       cmd_valid,
    output var  logic [3:0] cmd_op,
    output var  logic       cmd_query,
    output var  logic [2:0] cmd_value
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        cmd_valid = 1'b0;
        cmd_op = 4'h0;
        cmd_query = 1'b0;
        cmd_value = 3'h0;
    end
    // One command per call; op and value lines flip when idle (query is left as is) so stale values never look valid
    task automatic send(input logic [3:0] op, input logic q,
                        input logic [2:0] v);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_query <= q;
        cmd_value <= v;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        cmd_op <= ~op;
        cmd_value <= ~v;
    endtask
endmodule
`default_nettype wire

// ===== dv/spcmd_asserts.sv
`include "spcmd_map.vh"
`default_nettype none
// ****************
// Port checker
// ****************
module spcmd_asserts
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       cmd_valid,
    input wire logic [3:0] cmd_op,
    input wire logic       cmd_query,
    input wire logic [2:0] cmd_value,
    input wire logic       meas_running,
    input wire logic       cal_mode,
    input wire logic       temp_comp_on,
    input wire logic [3:0] spare_in,
    input wire logic       rsp_valid_r,
    input wire logic [1:0] rsp_status_r,
    input wire logic [3:0] rsp_data_r,
    input wire logic [2:0] spare_out_r,
    input wire logic       printer_on_r,
    input wire logic       prt_temp_r,
    input wire logic       prt_count_r,
    input wire logic       prt_tag_r,
    input wire logic       prt_clock_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire ok = !cal_mode && !meas_running;
    wire wr = cmd_valid && !cmd_query;
    chk_rsp_delay: assert property (cmd_valid |-> ##2 rsp_valid_r)
        else $error("answer late or missing");
    chk_no_spurious: assert property (rsp_valid_r
        |-> $past(cmd_valid, 2)) else $error("answer without command");
    chk_out_write: assert property (wr && ok
        && cmd_op == `SPCMD_OP_OUT_WR
        |=> spare_out_r == $past(cmd_value)) else $error("spare out wrong");
    chk_out_query: assert property (cmd_valid && ok && cmd_op == 4'h2
        ##1 1'b1 |=> rsp_data_r == {1'b0, $past(spare_out_r)})
        else $error("output query wrong");
    chk_cal_refuse: assert property (cmd_valid && cal_mode
        |-> ##2 rsp_status_r == `SPCMD_ST_CAL) else $error("cal not refused");
    chk_busy_refuse: assert property (cmd_valid && meas_running
        && !cal_mode && cmd_op inside {4'h1, 4'h2, 4'h3, [4'h6:4'h9]}
        |-> ##2 rsp_status_r == `SPCMD_ST_BUSY) else $error("busy not refused");
    chk_refuse_hold: assert property (cmd_valid && cal_mode
        |=> $stable(spare_out_r) && $stable(printer_on_r))
        else $error("refused command changed state");
    chk_prn_start: assert property (wr && !cal_mode && cmd_op == 4'h5
        |=> printer_on_r) else $error("printer not started");
    chk_prn_stop: assert property (wr && !cal_mode && cmd_op == 4'h4
        |=> !printer_on_r) else $error("printer not stopped");
    chk_count_flag: assert property (wr && ok && cmd_op == 4'h7
        |-> ##2 prt_count_r == ($past(cmd_value, 2) != 3'h0))
        else $error("count flag wrong");
    cover property (cmd_valid && cal_mode);
    cover property (cmd_valid && meas_running && cmd_op == 4'h5);
    cover property (rsp_valid_r && rsp_status_r == `SPCMD_ST_OK);
endmodule
bind spcmd_top spcmd_asserts spcmd_asserts_inst (.*);
`default_nettype wire

// ===== dv/spcmd_top_tb.sv
`default_nettype none
// ****************
// Command block bench
// ****************
module spcmd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst_n = 1'b0, meas_running = 1'b0, cal_mode = 1'b0;
    logic temp_comp_on = 1'b0;
    logic [3:0] spare_in = 4'h0;
    logic cmd_valid, cmd_query, rsp_valid_r, printer_on_r;
    logic prt_temp_r, prt_count_r, prt_tag_r, prt_clock_r;
    logic [3:0] cmd_op, rsp_data_r;
    logic [2:0] cmd_value, spare_out_r;
    logic [1:0] rsp_status_r;
    logic [5:0] expq[$];
    int failures = 0;
    int checked = 0;
    always #10 ref_clk = ~ref_clk;
    spcmd_top spcmd_top_inst (.*);
    spcmd_host spcmd_host_inst (.*);
    task chk(input logic [5:0] seen, input logic [5:0] want);
        checked++;
        if (seen !== want)
        begin
            failures++;
            $display("ERROR %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task go(input logic [3:0] op, input logic q, input logic [2:0] v,
            input logic [1:0] st, input logic [3:0] d);
        expq.push_back({st, d});
        spcmd_host_inst.send(op, q, v);
    endtask
    task tally_and_finish;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Answers are pipelined, so they are matched in order of issue
    always @(posedge ref_clk)
        if (rst_n && rsp_valid_r === 1'b1)
        begin
            if (expq.size() == 0)
            begin
                failures++;
                $display("ERROR %0t: unexpected answer", $time);
            end
            else
                chk({rsp_status_r, rsp_data_r}, expq.pop_front());
        end
    initial
    begin
        int i;
        int k;
        logic [3:0] s;
        void'($urandom(17550));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            go(4'h1, 1'b0, i[2:0], 2'h0, i[3:0]);
            @(negedge ref_clk);
            chk(spare_out_r, i[5:0]);
            go(4'h2, 1'b1, 3'h0, 2'h0, i[3:0]);
        end
        repeat (4)
        begin
            s = 4'($urandom);
            @(posedge ref_clk);
            spare_in <= s;
            repeat (4) @(posedge ref_clk);
            go(4'h3, 1'b1, 3'h0, 2'h0, s);
        end
        @(posedge ref_clk);
        temp_comp_on <= 1'b1;
        for (k = 0; k < 4; k++)
        begin
            go(4'h6 + k[3:0], 1'b0, 3'($urandom_range(7, 1)), 2'h0, 4'h1);
            @(negedge ref_clk);
            @(negedge ref_clk);
            chk({prt_clock_r, prt_tag_r, prt_count_r, prt_temp_r},
                6'(1 << k));
            go(4'h6 + k[3:0], 1'b1, 3'h0, 2'h0, 4'h1);
            go(4'h6 + k[3:0], 1'b0, 3'h0, 2'h0, 4'h0);
            go(4'h6 + k[3:0], 1'b1, 3'h0, 2'h0, 4'h0);
        end
        go(4'h6, 1'b0, 3'h1, 2'h0, 4'h1);
        temp_comp_on <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk(prt_temp_r, 6'h00);
        go(4'h6, 1'b0, 3'h0, 2'h0, 4'h0);
        go(4'h5, 1'b0, 3'h0, 2'h0, 4'h1);
        @(negedge ref_clk);
        chk(printer_on_r, 6'h01);
        go(4'h4, 1'b1, 3'h0, 2'h0, 4'h1);
        go(4'h4, 1'b0, 3'h0, 2'h0, 4'h0);
        @(negedge ref_clk);
        chk(printer_on_r, 6'h00);
        go(4'h5, 1'b1, 3'h0, 2'h0, 4'h0);
        @(posedge ref_clk);
        meas_running <= 1'b1;
        go(4'h1, 1'b0, 3'h2, 2'h1, 4'h0);
        go(4'h3, 1'b1, 3'h0, 2'h1, 4'h0);
        go(4'h7, 1'b0, 3'h1, 2'h1, 4'h0);
        go(4'h5, 1'b0, 3'h0, 2'h0, 4'h1);
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk({prt_count_r, spare_out_r}, 6'h07);
        @(posedge ref_clk);
        cal_mode <= 1'b1;
        // Calibration outranks a running measurement in the status code
        for (k = 1; k < 10; k++)
            go(k[3:0], 1'b0, 3'h0, 2'h2, 4'h0);
        @(negedge ref_clk);
        chk({printer_on_r, spare_out_r}, 6'h0F);
        @(posedge ref_clk);
        cal_mode <= 1'b0;
        meas_running <= 1'b0;
        go(4'hA, 1'b1, 3'h0, 2'h3, 4'h0);
        for (k = 0; k < 20 && expq.size() > 0; k++)
            @(posedge ref_clk);
        if (expq.size() > 0)
        begin
            failures++;
            $display("ERROR %0t: answers missing", $time);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
